// >>> pcx_defs.svh
`ifndef PCX_DEFS_SVH
`define PCX_DEFS_SVH

// ----------------------------------------------------------------
// register map (byte offsets and address[7:2] group numbers on the plain register port)
// ----------------------------------------------------------------
`define PCX_GRP_DATA                6'h00
`define PCX_GRP_MODE                6'h01
`define PCX_OFF_CROSSBAR_CFG_FIRST  8'h08
`define PCX_OFF_CROSSBAR_CFG_SECOND 8'h09
`define PCX_OFF_CROSSBAR_CFG_THIRD  8'h0a
`define PCX_OFF_PORT3_EDGE_IRQ      8'h0b

// ----------------------------------------------------------------
// sizes and reset values
// ----------------------------------------------------------------
`define PCX_NPINS      32
`define PCX_NSIG       28
`define PCX_NEDGE      2
`define PCX_RST_BYTE   8'h00
`define PCX_RST_DATA   32'hffffffff
`define PCX_RST_MODE   32'h00000000
`define PCX_IDLE_IN    1'b1

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define PCX_CF_SMB     0
`define PCX_CF_SPI     1
`define PCX_CF_SER_A   2
`define PCX_CF_PCA_LO  3
`define PCX_CF_ECI     6
`define PCX_CF_CMP_A   7
`define PCX_CS_CMP_B   0
`define PCX_CS_TMR_A   1
`define PCX_CS_IRQ_A   2
`define PCX_CS_TMR_B   3
`define PCX_CS_IRQ_B   4
`define PCX_CS_TMR_C   5
`define PCX_CS_TMR_CX  6
`define PCX_CS_SYS_CLOCK_OUT  7
`define PCX_CT_CNVST   0
`define PCX_CT_SER_B   2
`define PCX_CT_TMR_D   3
`define PCX_CT_TMR_DX  4
`define PCX_CT_GLOBAL  6
`define PCX_IRQ_EN_LO  0
`define PCX_IRQ_POL_LO 2
`define PCX_IRQ_FLG_LO 6

// ----------------------------------------------------------------
// signal indices in priority order, and signal class masks
// ----------------------------------------------------------------
`define PCX_SIG_TX_A   0
`define PCX_SIG_RX_A   1
`define PCX_SIG_SDA    6
`define PCX_SIG_RX_B   9
`define PCX_SIG_CEX0   10
`define PCX_NCEX       5
`define PCX_IN_ONLY    28'hbfc8202
`define PCX_FORCE_OD   28'h00000c0
`define PCX_P3_PIN6    30
`define PCX_P3_PIN7    31

`endif

// >>> pcx_pkg.sv
`include "pcx_defs.svh"
package pcx_pkg;
  typedef logic [7:0]              pcx_byte_t;
  typedef logic [4:0]              pcx_pin_t;
  typedef logic [`PCX_NPINS-1:0]   pcx_pins_t;
  typedef logic [`PCX_NSIG-1:0]    pcx_sigs_t;
  typedef logic [`PCX_NEDGE-1:0]   pcx_edge_t;
endpackage : pcx_pkg

// >>> pcx_edge_if.sv
`timescale 1ns/10ps
interface pcx_edge_if;
  logic level;
  logic polarity;
  logic clr;
  logic flag;
  modport ctl (output level, output polarity, output clr, input flag);
  modport det (input level, input polarity, input clr, output flag);
endinterface : pcx_edge_if

// >>> pcx_edge_det.sv
`timescale 1ns/10ps
`include "pcx_defs.svh"
module pcx_edge_det (
  input  wire logic mclk,
  input  wire logic reset_n,
  pcx_edge_if.det   eif
);
  import pcx_pkg::*;

  logic prev;
  logic flag;
  logic next_prev;
  logic next_flag;
  logic hit;

  // ----------------------------------------------------------------
  // edge detect on an already synchronised level
  // ----------------------------------------------------------------
  always_comb begin
    hit       = eif.polarity ? (eif.level & ~prev) : (~eif.level & prev);
    next_prev = eif.level;
    // a fresh edge beats a clear in the same cycle
    next_flag = hit ? 1'b1 : (eif.clr ? 1'b0 : flag); // RULE18
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      prev <= `PCX_IDLE_IN;
      flag <= 1'b0;
    end else begin
      prev <= next_prev;
      flag <= next_flag;
    end
  end

  assign eif.flag = flag;

  property p_edge_sets;
    @(posedge mclk) disable iff (!reset_n)
      (eif.polarity ? (eif.level && !prev) : (!eif.level && prev)) |=> flag;
  endproperty
  a_edge_sets: assert property (p_edge_sets) else $error("edge did not set flag"); // RULE18

  property p_flag_holds;
    @(posedge mclk) disable iff (!reset_n)
      (flag && !eif.clr) |=> flag;
  endproperty
  a_flag_holds: assert property (p_flag_holds) else $error("edge flag lost"); // RULE17
endmodule : pcx_edge_det

// >>> pcx_crossbar.sv
// Chosen here: the register addresses and the address-and-strobe port.
`timescale 1ns/10ps
`include "pcx_defs.svh"
// Functional notes
// RULE1 - allocate pins upward from port0 pin0
// RULE2 - only enabled functions reach pins
// RULE3 - low priority functions follow fixed order
// RULE4 - each enable set gives one pinout
// RULE5 - unallocated pins are software gpio
// RULE6 - allocated pin output comes from peripheral
// RULE7 - plain reads return pin level
// RULE8 - rmw reads return data latch
// RULE9 - crossbar active only with global enable
// RULE10 - drivers off while global enable clear
// RULE11 - peripheral input pins never driven
// RULE12 - push-pull drives data bit level
// RULE13 - open-drain drives low or releases
// RULE14 - mode bit 1 push-pull, reset open-drain
// RULE15 - serial bus and mode0 receive forced open-drain
// RULE16 - software sets input as open-drain one
// RULE17 - port3 pins 6,7 edge interrupts, selectable
// RULE18 - active edge sets its flag
// RULE19 - enabled flag raises interrupt request
// RULE20 - configure crossbar before global enable
module pcx_crossbar (
  input  wire logic               mclk,
  input  wire logic               reset_n,
  input  wire pcx_pkg::pcx_byte_t bus_addr,
  input  wire pcx_pkg::pcx_byte_t bus_wdata,
  input  wire logic               bus_wr,
  input  wire logic               bus_bit_wr,
  input  wire logic               bus_rd,
  input  wire logic               bus_rd_rmw,
  output      pcx_pkg::pcx_byte_t bus_rdata,
  input  wire pcx_pkg::pcx_pins_t pin_in,
  output      pcx_pkg::pcx_pins_t pin_out,
  output      pcx_pkg::pcx_pins_t pin_oe,
  input  wire pcx_pkg::pcx_sigs_t periph_out,
  input  wire pcx_pkg::pcx_sigs_t periph_oe,
  output      pcx_pkg::pcx_sigs_t periph_in,
  input  wire logic               serial_a_mode0,
  input  wire logic               serial_b_mode0,
  output      pcx_pkg::pcx_edge_t edge_irq_req
);
  import pcx_pkg::*;

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  pcx_pins_t data_lat;
  pcx_pins_t mode_lat;
  pcx_byte_t cfg_first;
  pcx_byte_t cfg_second;
  pcx_byte_t cfg_third;
  pcx_byte_t irq_ctl;
  pcx_pins_t next_data_lat;
  pcx_pins_t next_mode_lat;
  pcx_byte_t next_cfg_first;
  pcx_byte_t next_cfg_second;
  pcx_byte_t next_cfg_third;
  pcx_byte_t next_irq_ctl;
  pcx_byte_t next_rdata;
  pcx_edge_t irq_flag;
  pcx_edge_t irq_clr;
  pcx_edge_t next_irq_req;
  logic      crossbar_global_enable;

  // ----------------------------------------------------------------
  // pin synchroniser
  // ----------------------------------------------------------------
  pcx_pins_t pin_meta;
  pcx_pins_t pin_sync;

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pin_meta <= `PCX_RST_DATA;
      pin_sync <= `PCX_RST_DATA;
    end else begin
      pin_meta <= pin_in;
      pin_sync <= pin_meta;
    end
  end
  assign crossbar_global_enable = cfg_third[`PCX_CT_GLOBAL];

  // ----------------------------------------------------------------
  // register port
  // ----------------------------------------------------------------
  always_comb begin
    next_data_lat   = data_lat;
    next_mode_lat   = mode_lat;
    next_cfg_first  = cfg_first;
    next_cfg_second = cfg_second;
    next_cfg_third  = cfg_third;
    next_irq_ctl    = irq_ctl;
    irq_clr         = '0;
    next_rdata      = `PCX_RST_BYTE;
    // latch always takes writes; it only reaches unallocated pins
    if (bus_wr && bus_bit_wr && bus_addr[7:2] == `PCX_GRP_DATA) begin
      next_data_lat[{bus_addr[1:0], bus_wdata[2:0]}] = bus_wdata[7]; // RULE5
    end else if (bus_wr && !bus_bit_wr) begin
      if (bus_addr[7:2] == `PCX_GRP_DATA) begin
        next_data_lat[{bus_addr[1:0], 3'h0} +: 8] = bus_wdata; // RULE5
      end else if (bus_addr[7:2] == `PCX_GRP_MODE) begin
        next_mode_lat[{bus_addr[1:0], 3'h0} +: 8] = bus_wdata; // RULE14
      end else if (bus_addr == `PCX_OFF_CROSSBAR_CFG_FIRST) begin
        next_cfg_first = bus_wdata;
      end else if (bus_addr == `PCX_OFF_CROSSBAR_CFG_SECOND) begin
        next_cfg_second = bus_wdata;
      end else if (bus_addr == `PCX_OFF_CROSSBAR_CFG_THIRD) begin
        next_cfg_third = bus_wdata; // RULE9
      end else if (bus_addr == `PCX_OFF_PORT3_EDGE_IRQ) begin
        next_irq_ctl = bus_wdata;
        // writing zero to a flag bit clears it
        irq_clr = ~bus_wdata[`PCX_IRQ_FLG_LO +: `PCX_NEDGE];
      end
    end
    if (bus_rd) begin
      if (bus_addr[7:2] == `PCX_GRP_DATA) begin
        next_rdata = bus_rd_rmw ? data_lat[{bus_addr[1:0], 3'h0} +: 8] // RULE8
                                : pin_sync[{bus_addr[1:0], 3'h0} +: 8]; // RULE7
      end else if (bus_addr[7:2] == `PCX_GRP_MODE) begin
        next_rdata = mode_lat[{bus_addr[1:0], 3'h0} +: 8];
      end else if (bus_addr == `PCX_OFF_CROSSBAR_CFG_FIRST) begin
        next_rdata = cfg_first;
      end else if (bus_addr == `PCX_OFF_CROSSBAR_CFG_SECOND) begin
        next_rdata = cfg_second;
      end else if (bus_addr == `PCX_OFF_CROSSBAR_CFG_THIRD) begin
        next_rdata = cfg_third;
      end else if (bus_addr == `PCX_OFF_PORT3_EDGE_IRQ) begin
        next_rdata = {irq_flag, 2'h0, irq_ctl[3:0]};
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      data_lat   <= `PCX_RST_DATA;
      mode_lat   <= `PCX_RST_MODE; // RULE14
      cfg_first  <= `PCX_RST_BYTE;
      cfg_second <= `PCX_RST_BYTE;
      cfg_third  <= `PCX_RST_BYTE;
      irq_ctl    <= `PCX_RST_BYTE;
      bus_rdata  <= `PCX_RST_BYTE;
    end else begin
      data_lat   <= next_data_lat;
      mode_lat   <= next_mode_lat;
      cfg_first  <= next_cfg_first;
      cfg_second <= next_cfg_second;
      cfg_third  <= next_cfg_third;
      irq_ctl    <= next_irq_ctl;
      bus_rdata  <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // priority allocation
  // ----------------------------------------------------------------
  pcx_sigs_t sig_en;
  pcx_sigs_t alloc;
  pcx_pin_t  pin_of [`PCX_NSIG];
  logic [5:0] cnt;

  always_comb begin
    sig_en = '0;
    sig_en[1:0]   = {2{cfg_first[`PCX_CF_SER_A]}};
    sig_en[5:2]   = {4{cfg_first[`PCX_CF_SPI]}}; // RULE4
    sig_en[7:6]   = {2{cfg_first[`PCX_CF_SMB]}};
    sig_en[9:8]   = {2{cfg_third[`PCX_CT_SER_B]}};
    for (int i = 0; i < `PCX_NCEX; i++) begin
      sig_en[`PCX_SIG_CEX0 + i] = (cfg_first[`PCX_CF_PCA_LO +: 3] > 3'(i));
    end
    sig_en[15] = cfg_first[`PCX_CF_ECI];
    sig_en[16] = cfg_first[`PCX_CF_CMP_A]; // RULE3
    sig_en[17] = cfg_second[`PCX_CS_CMP_B];
    sig_en[18] = cfg_second[`PCX_CS_TMR_A];
    sig_en[19] = cfg_second[`PCX_CS_IRQ_A];
    sig_en[20] = cfg_second[`PCX_CS_TMR_B];
    sig_en[21] = cfg_second[`PCX_CS_IRQ_B];
    sig_en[22] = cfg_second[`PCX_CS_TMR_C];
    sig_en[23] = cfg_second[`PCX_CS_TMR_CX];
    sig_en[24] = cfg_third[`PCX_CT_TMR_D];
    sig_en[25] = cfg_third[`PCX_CT_TMR_DX];
    sig_en[26] = cfg_second[`PCX_CS_SYS_CLOCK_OUT];
    sig_en[27] = cfg_third[`PCX_CT_CNVST];
    // all signals fit: 28 signals, 32 pins
    cnt = 6'h00;
    for (int s = 0; s < `PCX_NSIG; s++) begin
      alloc[s]  = sig_en[s] & crossbar_global_enable; // RULE2 RULE9
      pin_of[s] = cnt[4:0]; // RULE1
      if (alloc[s]) begin
        cnt = cnt + 6'h01;
      end
    end
  end

  // ----------------------------------------------------------------
  // pin drivers and peripheral inputs
  // ----------------------------------------------------------------
  pcx_pins_t next_pin_out;
  pcx_pins_t next_pin_oe;
  pcx_sigs_t next_periph_in;
  pcx_sigs_t in_only;
  pcx_sigs_t force_od;

  always_comb begin
    logic owned;
    logic val;
    logic pp;
    logic req;
    owned    = 1'b0;
    val      = 1'b0;
    pp       = 1'b0;
    req      = 1'b0;
    // mode0 receive lines carry a driven shift clock/data, so not input only
    in_only  = `PCX_IN_ONLY;
    in_only[`PCX_SIG_RX_A] = ~serial_a_mode0;
    in_only[`PCX_SIG_RX_B] = ~serial_b_mode0;
    force_od = `PCX_FORCE_OD;
    force_od[`PCX_SIG_RX_A] = serial_a_mode0; // RULE15
    force_od[`PCX_SIG_RX_B] = serial_b_mode0; // RULE15
    for (int p = 0; p < `PCX_NPINS; p++) begin
      owned = 1'b0;
      val   = data_lat[p];
      pp    = mode_lat[p];
      req   = 1'b1;
      for (int s = 0; s < `PCX_NSIG; s++) begin
        if (alloc[s] && pin_of[s] == 5'(p)) begin
          owned = 1'b1;
          val   = periph_out[s]; // RULE6
          pp    = mode_lat[p] & ~force_od[s]; // RULE15
          req   = periph_oe[s] & ~in_only[s]; // RULE11
        end
      end
      next_pin_out[p] = val; // RULE12
      // open-drain drives only a zero
      next_pin_oe[p]  = crossbar_global_enable & req & (pp | ~val); // RULE10 RULE13
    end
    for (int s = 0; s < `PCX_NSIG; s++) begin
      next_periph_in[s] = alloc[s] ? pin_sync[pin_of[s]] : `PCX_IDLE_IN;
    end
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      pin_out   <= `PCX_RST_DATA;
      pin_oe    <= '0;
      periph_in <= '1;
    end else begin
      pin_out   <= next_pin_out;
      pin_oe    <= next_pin_oe;
      periph_in <= next_periph_in;
    end
  end

  // ----------------------------------------------------------------
  // port3 edge interrupts
  // ----------------------------------------------------------------
  localparam int EDGE_PIN [`PCX_NEDGE] = '{`PCX_P3_PIN6, `PCX_P3_PIN7};
  for (genvar g = 0; g < `PCX_NEDGE; g++) begin : g_edge
    pcx_edge_if eif ();
    assign eif.level    = pin_sync[EDGE_PIN[g]]; // RULE17
    assign eif.polarity = irq_ctl[`PCX_IRQ_POL_LO + g]; // RULE17
    assign eif.clr      = irq_clr[g];
    assign irq_flag[g]  = eif.flag;
    pcx_edge_det u_det (
      .mclk    (mclk),
      .reset_n (reset_n),
      .eif     (eif)
    );
  end

  always_comb begin
    next_irq_req = irq_flag & irq_ctl[`PCX_IRQ_EN_LO +: `PCX_NEDGE]; // RULE19
  end

  always_ff @(posedge mclk) begin
    if (!reset_n) begin
      edge_irq_req <= '0;
    end else begin
      edge_irq_req <= next_irq_req;
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking

  property p_drv_off;
    disable iff (!reset_n) !crossbar_global_enable |=> pin_oe == '0;
  endproperty
  a_drv_off: assert property (p_drv_off) else $error("driver on while disabled"); // RULE10
  property p_pin_read;
    disable iff (!reset_n)
      (bus_rd && !bus_rd_rmw && bus_addr == 8'h00) |=> bus_rdata == $past(pin_sync[7:0]);
  endproperty
  a_pin_read: assert property (p_pin_read) else $error("read not pin level"); // RULE7
  property p_rmw_read;
    disable iff (!reset_n)
      (bus_rd && bus_rd_rmw && bus_addr == 8'h02) |=> bus_rdata == $past(data_lat[23:16]);
  endproperty
  a_rmw_read: assert property (p_rmw_read) else $error("rmw read not latch"); // RULE8
  property p_first_pin;
    disable iff (!reset_n)
      alloc[`PCX_SIG_TX_A] |-> pin_of[`PCX_SIG_TX_A] == 5'h00 && pin_of[`PCX_SIG_RX_A] == 5'h01;
  endproperty
  a_first_pin: assert property (p_first_pin) else $error("top function not at pin 0"); // RULE1
  property p_rx_undriven;
    disable iff (!reset_n) (alloc[`PCX_SIG_RX_A] && !serial_a_mode0) |=> !pin_oe[1];
  endproperty
  a_rx_undriven: assert property (p_rx_undriven) else $error("input pin driven"); // RULE11
  // pin 0 is gpio only when nothing at all is allocated
  property p_gpio_pp;
    disable iff (!reset_n) (crossbar_global_enable && alloc == '0 && mode_lat[0])
      |=> pin_oe[0] && pin_out[0] == $past(data_lat[0]);
  endproperty
  a_gpio_pp: assert property (p_gpio_pp) else $error("push-pull gpio wrong"); // RULE12
  property p_gpio_od;
    disable iff (!reset_n) (sig_en == '0 && !mode_lat[31] && data_lat[31]) |=> !pin_oe[31];
  endproperty
  a_gpio_od: assert property (p_gpio_od) else $error("open-drain one driven"); // RULE13
  property p_tx_follows;
    disable iff (!reset_n) (alloc[`PCX_SIG_TX_A] && mode_lat[0] && periph_oe[0])
      |=> pin_oe[0] && pin_out[0] == $past(periph_out[0]);
  endproperty
  a_tx_follows: assert property (p_tx_follows) else $error("pin not from peripheral"); // RULE6
  property p_sda_od;
    disable iff (!reset_n)
      (alloc[`PCX_SIG_SDA] && periph_out[`PCX_SIG_SDA]) |=> !pin_oe[$past(pin_of[`PCX_SIG_SDA])];
  endproperty
  a_sda_od: assert property (p_sda_od) else $error("bus line not open-drain"); // RULE15
  property p_irq_req;
    disable iff (!reset_n) (irq_flag[0] && irq_ctl[`PCX_IRQ_EN_LO]) |=> edge_irq_req[0];
  endproperty
  a_irq_req: assert property (p_irq_req) else $error("enabled flag no request"); // RULE19

  c_uart: cover property (disable iff (!reset_n) alloc[`PCX_SIG_TX_A] && pin_oe[0]);
  c_rmw: cover property (disable iff (!reset_n) bus_rd && bus_rd_rmw);
  c_irq: cover property (disable iff (!reset_n) $rose(edge_irq_req[1]));
endmodule : pcx_crossbar

// >>> pcx_pin_model.sv
`timescale 1ns/10ps
module pcx_pin_model
  import pcx_pkg::*;
(
  input  wire pcx_pkg::pcx_pins_t pin_out,
  input  wire pcx_pkg::pcx_pins_t pin_oe,
  input  wire pcx_pkg::pcx_pins_t ext_oe,
  input  wire pcx_pkg::pcx_pins_t ext_val,
  output      pcx_pkg::pcx_pins_t pin_in
);
  // ----------------------------------------------------------------
  // pad resolution
  // ----------------------------------------------------------------
  // a pin nobody drives sits at the pull-up level, never at the last value
  pcx_pins_t drv_any;
  pcx_pins_t drv_lvl;
  assign drv_any = pin_oe | ext_oe;
  assign drv_lvl = (pin_oe & pin_out) | (~pin_oe & ext_oe & ext_val);
  // the device wins a clash here; the priority and comparator scenarios drive pin 2 from both sides
  assign pin_in  = (drv_any & drv_lvl) | ~drv_any;
endmodule : pcx_pin_model

// >>> test_priority_crossbar_port_io.sv
`timescale 1ns/10ps
module test_priority_crossbar_port_io;
  import pcx_pkg::*;
  logic        mclk;
  logic        reset_n;
  pcx_byte_t   bus_addr;
  pcx_byte_t   bus_wdata;
  logic        bus_wr;
  logic        bus_bit_wr;
  logic        bus_rd;
  logic        bus_rd_rmw;
  pcx_byte_t   bus_rdata;
  pcx_pins_t   pin_in;
  pcx_pins_t   pin_out;
  pcx_pins_t   pin_oe;
  pcx_pins_t   ext_oe;
  pcx_pins_t   ext_val;
  pcx_sigs_t   periph_out;
  pcx_sigs_t   periph_oe;
  pcx_sigs_t   periph_in;
  logic        serial_a_mode0;
  logic        serial_b_mode0;
  pcx_edge_t   edge_irq_req;
  int          num_errors;
  int          total_checks;
  logic [15:0] rd_q[$];
  logic [15:0] rd_note;
  logic        rd_seen;
  pcx_byte_t   d;
  int          i;
  int          sig;

  pcx_crossbar u_dut (.mclk(mclk), .reset_n(reset_n), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_bit_wr(bus_bit_wr), .bus_rd(bus_rd),
    .bus_rd_rmw(bus_rd_rmw), .bus_rdata(bus_rdata), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .periph_out(periph_out), .periph_oe(periph_oe),
    .periph_in(periph_in), .serial_a_mode0(serial_a_mode0),
    .serial_b_mode0(serial_b_mode0), .edge_irq_req(edge_irq_req));

  pcx_pin_model u_pins (.pin_out(pin_out), .pin_oe(pin_oe), .ext_oe(ext_oe),
    .ext_val(ext_val), .pin_in(pin_in));

  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask : idle

  task automatic wr(input pcx_byte_t a, input pcx_byte_t v, input logic bitw);
    @(posedge mclk);
    bus_wr     <= 1'b1;
    bus_bit_wr <= bitw;
    bus_addr   <= a;
    bus_wdata  <= v;
    @(posedge mclk);
    bus_wr     <= 1'b0;
    bus_bit_wr <= 1'b0;
    #1;
  endtask : wr

  // the expected byte is noted first; the monitor takes it when data stand
  task automatic rd(input pcx_byte_t a, input logic rmw, input pcx_byte_t exp);
    rd_q.push_back({a, exp});
    @(posedge mclk);
    bus_rd     <= 1'b1;
    bus_rd_rmw <= rmw;
    bus_addr   <= a;
    @(posedge mclk);
    bus_rd     <= 1'b0;
    bus_rd_rmw <= 1'b0;
    #1;
  endtask : rd

  task automatic setx(input int p, input logic o, input logic v);
    @(posedge mclk);
    ext_oe[p]  <= o;
    ext_val[p] <= v;
    idle(6);
  endtask : setx

  // ----------------------------------------------------------------
  // read monitor
  // ----------------------------------------------------------------
  always @(posedge mclk) begin
    if (rd_seen) begin
      rd_note = rd_q.pop_front();
      chk($sformatf("rdata@%h", rd_note[15:8]), 32'(rd_note[7:0]), 32'(bus_rdata));
    end
    rd_seen = bus_rd;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    $display("Error watchdog expected done seen hang");
    tally_and_finish();
  end

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    num_errors = 0;
    total_checks = 0;
    rd_seen = 1'b0;
    reset_n <= 1'b0;
    bus_addr <= 8'h00;
    bus_wdata <= 8'h00;
    bus_wr <= 1'b0;
    bus_bit_wr <= 1'b0;
    bus_rd <= 1'b0;
    bus_rd_rmw <= 1'b0;
    ext_oe <= 32'h0;
    ext_val <= 32'h0;
    periph_out <= 28'h0;
    periph_oe <= 28'hfffffff;
    serial_a_mode0 <= 1'b0;
    serial_b_mode0 <= 1'b0;
    void'($urandom(32'h39f8fcf4));
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    idle(3);
    for (i = 0; i < 12; i++) begin
      rd(i[7:0], 1'b0, (i < 4) ? 8'hff : 8'h00);
    end
    rd(8'h0c, 1'b0, 8'h00);
    rd(8'h00, 1'b1, 8'hff);
    chk("oe_reset", 32'h0, pin_oe);
    d = 8'($urandom());
    wr(8'h00, d, 1'b0);
    wr(8'h04, 8'hff, 1'b0);
    idle(4);
    chk("oe_gated", 32'h0, pin_oe);
    rd(8'h00, 1'b1, d);
    rd(8'h00, 1'b0, 8'hff);
    wr(8'h0a, 8'h40, 1'b0);
    idle(4);
    chk("oe_pp", 32'hff, {24'h0, pin_oe[7:0]});
    chk("out_pp", {24'h0, d}, {24'h0, pin_out[7:0]});
    rd(8'h00, 1'b0, d);
    wr(8'h04, 8'h00, 1'b0);
    idle(4);
    chk("oe_od", {24'h0, ~d}, {24'h0, pin_oe[7:0]});
    rd(8'h00, 1'b0, d);
    for (i = 8; i < 16; i++) setx(i, 1'b1, 1'b0);
    rd(8'h01, 1'b0, 8'h00);
    chk("oe_in", 32'h0, {24'h0, pin_oe[15:8]});
    wr(8'h02, 8'h05, 1'b1);
    idle(4);
    rd(8'h02, 1'b1, 8'hdf);
    chk("oe_bit", 32'h20, {24'h0, pin_oe[23:16]});
    for (i = 8; i < 16; i++) setx(i, 1'b0, 1'b0);
    // serial port a takes pins 0 and 1 together
    wr(8'h04, 8'hff, 1'b0);
    periph_out <= 28'($urandom());
    wr(8'h08, 8'h04, 1'b0);
    setx(1, 1'b1, 1'b0);
    chk("oe_ser", 32'h1, {30'h0, pin_oe[1:0]});
    wr(8'h00, ~d, 1'b0);
    idle(4);
    chk("out_ser", {31'h0, periph_out[0]}, {31'h0, pin_out[0]});
    chk("in_ser", 32'h0, {31'h0, periph_in[1]});
    rd(8'h00, 1'b0, {~d[7:2], 1'b0, periph_out[0]});
    setx(1, 1'b0, 1'b0);
    serial_a_mode0 <= 1'b1;
    periph_out[1] <= 1'b1;
    idle(4);
    chk("oe_mode0", 32'h0, {31'h0, pin_oe[1]});
    periph_out[1] <= 1'b0;
    idle(4);
    chk("oe_mode0_low", 32'h1, {31'h0, pin_oe[1]});
    serial_a_mode0 <= 1'b0;
    periph_out[0] <= 1'b1;
    periph_out[7:6] <= 2'b01;
    wr(8'h08, 8'h05, 1'b0);
    idle(4);
    chk("oe_smb", 32'h9, {28'h0, pin_oe[3:0]});
    wr(8'h08, 8'h80, 1'b0);
    idle(4);
    chk("out_cmp0", {31'h0, periph_out[16]}, {31'h0, pin_out[0]});
    wr(8'h08, 8'h00, 1'b0);
    setx(1, 1'b1, 1'b0);
    chk("in_off", 32'h1, {31'h0, periph_in[1]});
    chk("out_off", {31'h0, ~d[0]}, {31'h0, pin_out[0]});
    setx(1, 1'b0, 1'b0);
    // each function from signal 17 to signal 27 lands just after the serial pair
    setx(2, 1'b1, 1'b0);
    for (i = 0; i < 11; i++) begin
      sig = (i < 7) ? 17 + i : (i == 7) ? 26 : (i == 8) ? 27 : 15 + i;
      periph_out <= 28'($urandom());
      wr(8'h08, 8'h04, 1'b0);
      wr(8'h09, (i < 8) ? 8'h01 << i : 8'h00, 1'b0);
      wr(8'h0a, (i < 8) ? 8'h40 : (i == 8) ? 8'h41 : 8'h40 | (8'h01 << (i - 6)), 1'b0);
      idle(5);
      if (sig == 17 || sig == 26) begin
        chk($sformatf("out_sig%0d", sig), {31'h0, periph_out[sig]}, {31'h0, pin_out[2]});
        chk("oe_sig", 32'h1, {31'h0, pin_oe[2]});
      end else begin
        chk($sformatf("in_sig%0d", sig), 32'h0, {31'h0, periph_in[sig]});
        chk("oe_sig", 32'h0, {31'h0, pin_oe[2]});
      end
    end
    // both comparators: the first takes pin 2, the second pin 3
    periph_out[17:16] <= 2'b10;
    wr(8'h08, 8'h84, 1'b0);
    wr(8'h09, 8'h01, 1'b0);
    wr(8'h0a, 8'h40, 1'b0);
    idle(5);
    chk("cmp0_pos", 32'h0, {31'h0, pin_out[2]});
    chk("cmp1_pos", 32'h1, {31'h0, pin_out[3]});
    // serial port b alone in mode 0: its receive line may pull low
    serial_b_mode0 <= 1'b1;
    periph_out[9] <= 1'b0;
    wr(8'h08, 8'h00, 1'b0);
    wr(8'h09, 8'h00, 1'b0);
    wr(8'h0a, 8'h44, 1'b0);
    idle(5);
    chk("oe_rx_b_mode0", 32'h1, {31'h0, pin_oe[1]});
    serial_b_mode0 <= 1'b0;
    setx(2, 1'b0, 1'b0);
    // edge flags on port 3 pins 6 and 7
    wr(8'h08, 8'h00, 1'b0);
    wr(8'h09, 8'h00, 1'b0);
    wr(8'h0a, 8'h40, 1'b0);
    wr(8'h0b, 8'h07, 1'b0);
    setx(30, 1'b1, 1'b1);
    setx(31, 1'b1, 1'b1);
    rd(8'h0b, 1'b0, 8'h07);
    setx(30, 1'b1, 1'b0);
    rd(8'h0b, 1'b0, 8'h07);
    setx(30, 1'b1, 1'b1);
    rd(8'h0b, 1'b0, 8'h47);
    chk("irq_a", 32'h1, {30'h0, edge_irq_req});
    setx(31, 1'b1, 1'b0);
    rd(8'h0b, 1'b0, 8'hc7);
    chk("irq_ab", 32'h3, {30'h0, edge_irq_req});
    wr(8'h0b, 8'h07, 1'b0);
    idle(3);
    rd(8'h0b, 1'b0, 8'h07);
    chk("irq_clr", 32'h0, {30'h0, edge_irq_req});
    setx(31, 1'b1, 1'b1);
    rd(8'h0b, 1'b0, 8'h07);
    wr(8'h0b, 8'h00, 1'b0);
    setx(30, 1'b1, 1'b0);
    rd(8'h0b, 1'b0, 8'h40);
    chk("irq_masked", 32'h0, {30'h0, edge_irq_req});
    idle(3);
    chk("queue_empty", 32'h0, rd_q.size());
    tally_and_finish();
  end
endmodule : test_priority_crossbar_port_io
